// File: verilog/sbg_branch_gate.sv
// sequencer branch decision, playback waits and pulse counter gating
// What this block does
// - next waveform chosen from parallel input value
// - level read yields one bit picking branch
// - rise and fall off means level sensitive
// - level source: pin or demod versus threshold
// - wait-for-end stalls until playback has finished
// - phase wait holds until oscillator reference
// - start locked to clock, one-period quantisation
// - gated free running counts between gate edges
// - gated mode: gate rise resets counter timer
// - gate chosen among sequencer trigger outputs 1-4
// - one oscillator select shared with averager
`timescale 1ns/1ps
module sbg_branch_gate (
  // clock, reset, freeze
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic ce_in,
  // avalon-mm slave
  input wire logic [sbg_pkg::AW-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [sbg_pkg::DW-1:0] avs_writedata_in,
  output logic [sbg_pkg::DW-1:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // pins from outside
  input wire logic ext_trig_in,
  input wire logic [sbg_pkg::DW-1:0] par_in,
  input wire logic cnt_pulse_in,
  // same-clock inputs
  input wire logic [sbg_pkg::THR_W-1:0] demod_in,
  input wire logic [sbg_pkg::OSC_N-1:0] osc_phase_in,
  input wire logic wave_busy_in,
  // sequencer outputs
  output logic emit_req_out,
  output logic [sbg_pkg::IDX_W-1:0] emit_index_out,
  output logic [sbg_pkg::TRIG_N-1:0] seq_trig_out,
  output logic [2:0] osc_sel_out,
  output logic trig_state_out,
  output logic seq_busy_out
);
  import sbg_pkg::*;
  function automatic logic rise_of(input logic cur, input logic prev);
    return cur & ~prev;
  endfunction
  // pin synchronisers; multi-bit parallel input may skew by a cycle
  logic trig_s1_q, trig_s2_q, cnt_s1_q, cnt_s2_q, cnt_s3_q;
  logic [DW-1:0] par_s1_q, par_s2_q;
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      trig_s1_q <= 1'b0;
      trig_s2_q <= 1'b0;
      cnt_s1_q <= 1'b0;
      cnt_s2_q <= 1'b0;
      cnt_s3_q <= 1'b0;
      par_s1_q <= '0;
      par_s2_q <= '0;
    end else if (ce_in) begin
      trig_s1_q <= ext_trig_in;
      trig_s2_q <= trig_s1_q;
      cnt_s1_q <= cnt_pulse_in;
      cnt_s2_q <= cnt_s1_q;
      cnt_s3_q <= cnt_s2_q;
      par_s1_q <= par_in;
      par_s2_q <= par_s1_q;
    end
  end
  // state declarations
  sbg_ctrl_type ctrl_q, ctrl_d;
  sbg_cmd_type cmd_q, cmd_d;
  sbg_state_type st_q, st_d;
  logic [THR_W-1:0] thr_q, thr_d;
  logic [DW-1:0] per_q, per_d, rdata_q, rdata_d, par_cap_q, par_cap_d;
  logic [DW-1:0] tmr_q, tmr_d, cnt_q, cnt_d, res_q, res_d;
  logic [TRIG_N-1:0] trig_q, trig_d;
  logic wait_q, wait_d, go_q, go_d;
  logic tstate_q, tstate_d, lvl_prev_q, gate_prev_q;
  logic emit_q, emit_d, busy_q, busy_d, branch_q, branch_d;
  logic [IDX_W-1:0] idx_q, idx_d;
  logic req, wr_take, level_now, edge_hit, level_mode, consume;
  logic gate, pulse;
  // bus: one wait cycle, then the answer edge
  assign req = avs_read_in | avs_write_in;
  assign wr_take = avs_write_in & ~wait_q;
  // register file and bus answer
  always_comb begin
    ctrl_d = ctrl_q;
    thr_d = thr_q;
    per_d = per_q;
    cmd_d = cmd_q;
    trig_d = trig_q;
    go_d = 1'b0;
    wait_d = ~(req & wait_q);
    rdata_d = rdata_q;
    if (avs_read_in & wait_q) begin
      unique case (avs_address_in)
        OFF_CTRL: rdata_d = DW'(ctrl_q);
        OFF_THRESH: rdata_d = DW'(thr_q);
        OFF_TIMER: rdata_d = per_q;
        OFF_CMD: rdata_d = DW'({branch_q, tstate_q, busy_q});
        OFF_PARIN: rdata_d = par_cap_q;
        OFF_COUNT: rdata_d = res_q;
        OFF_TRIG: rdata_d = DW'(trig_q);
        default: rdata_d = '0;
      endcase
    end
    if (wr_take) begin
      unique case (avs_address_in)
        OFF_CTRL: ctrl_d = sbg_ctrl_type'(avs_writedata_in[$bits(sbg_ctrl_type)-1:0]);
        OFF_THRESH: thr_d = avs_writedata_in[THR_W-1:0];
        OFF_TIMER: per_d = avs_writedata_in;
        OFF_CMD: begin
          // a command written while busy is dropped
          if (st_q == ST_IDLE) begin
            cmd_d = sbg_cmd_type'(avs_writedata_in[$bits(sbg_cmd_type)-1:0]);
            go_d = 1'b1;
          end
        end
        OFF_TRIG: trig_d = avs_writedata_in[TRIG_N-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_q <= '0;
      thr_q <= THRESH_RST;
      per_q <= TIMER_RST;
      cmd_q <= '0;
      trig_q <= TRIG_RST;
      go_q <= 1'b0;
      wait_q <= 1'b1;
      rdata_q <= '0;
    end else if (ce_in) begin
      ctrl_q <= ctrl_d;
      thr_q <= thr_d;
      per_q <= per_d;
      cmd_q <= cmd_d;
      trig_q <= trig_d;
      go_q <= go_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // level trigger source and sensing
  always_comb begin
    level_now = ctrl_q.src_demod ? ($signed(demod_in) >= $signed(thr_q)) : trig_s2_q;
    level_mode = ~ctrl_q.rise_en & ~ctrl_q.fall_en;
    edge_hit = (ctrl_q.rise_en & rise_of(level_now, lvl_prev_q))
      | (ctrl_q.fall_en & rise_of(lvl_prev_q, level_now));
    consume = (st_q == ST_EVAL) & (cmd_q.op == OP_LEVEL);
    if (level_mode) begin
      tstate_d = level_now;
    end else if (edge_hit) begin
      tstate_d = 1'b1; // new edge beats the read clear
    end else if (consume) begin
      tstate_d = 1'b0;
    end else begin
      tstate_d = tstate_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tstate_q <= 1'b0;
      lvl_prev_q <= 1'b0;
    end else if (ce_in) begin
      tstate_q <= tstate_d;
      lvl_prev_q <= level_now;
    end
  end

  // sequencer instruction walk
  always_comb begin
    st_d = st_q;
    emit_d = 1'b0;
    idx_d = idx_q;
    branch_d = branch_q;
    par_cap_d = par_cap_q;
    unique case (st_q)
      ST_IDLE: begin
        if (go_q) begin
          st_d = cmd_q.wait_end ? ST_WEND : (cmd_q.wait_phase ? ST_WPH : ST_EVAL);
        end
      end
      ST_WEND: begin
        if (!wave_busy_in) begin
          st_d = cmd_q.wait_phase ? ST_WPH : ST_EVAL;
        end
      end
      ST_WPH: begin
        if (osc_phase_in[ctrl_q.osc_sel]) begin
          st_d = ST_EVAL;
        end
      end
      ST_EVAL: begin
        emit_d = 1'b1;
        st_d = ST_IDLE;
        if (cmd_q.op == OP_LEVEL) begin
          branch_d = tstate_q;
          idx_d = tstate_q ? cmd_q.idx_hi : cmd_q.idx_lo;
        end else if (cmd_q.op == OP_PAR) begin
          par_cap_d = par_s2_q;
          idx_d = par_s2_q[IDX_W-1:0];
        end else begin
          idx_d = cmd_q.idx_lo;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    busy_d = (st_d != ST_IDLE);
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_q <= ST_IDLE;
      emit_q <= 1'b0;
      idx_q <= '0;
      branch_q <= 1'b0;
      par_cap_q <= '0;
      busy_q <= 1'b0;
    end else if (ce_in) begin
      st_q <= st_d;
      emit_q <= emit_d;
      idx_q <= idx_d;
      branch_q <= branch_d;
      par_cap_q <= par_cap_d;
      busy_q <= busy_d;
    end
  end

  // pulse counter gated by a sequencer trigger output
  // gate picked from outputs
  assign gate = trig_q[ctrl_q.gate_sel];
  assign pulse = rise_of(cnt_s2_q, cnt_s3_q);

  always_comb begin
    tmr_d = tmr_q + 32'h1;
    cnt_d = cnt_q;
    res_d = res_q;
    if (ctrl_q.cnt_mode == CNT_GATED_FREE) begin
      tmr_d = '0;
      if (gate & pulse) begin
        cnt_d = cnt_q + 32'h1;
      end
      if (rise_of(gate_prev_q, gate)) begin
        res_d = cnt_q;
        cnt_d = '0;
      end
    end else begin
      if (pulse) begin
        cnt_d = cnt_q + 32'h1;
      end
      if (tmr_q >= per_q - 32'h1) begin
        res_d = cnt_d;
        cnt_d = '0;
        tmr_d = '0;
      end
      if ((ctrl_q.cnt_mode == CNT_GATED) && rise_of(gate, gate_prev_q)) begin
        tmr_d = '0;
        cnt_d = '0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tmr_q <= '0;
      cnt_q <= '0;
      res_q <= '0;
      gate_prev_q <= 1'b0;
    end else if (ce_in) begin
      tmr_q <= tmr_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      gate_prev_q <= gate;
    end
  end
  // outputs straight from flops
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign emit_req_out = emit_q;
  assign emit_index_out = idx_q;
  assign seq_trig_out = trig_q;
  assign osc_sel_out = ctrl_q.osc_sel;
  assign trig_state_out = tstate_q;
  assign seq_busy_out = busy_q;

  // checks; a frozen cycle aborts the attempt
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in || !ce_in);
  sequence eval_then_emit;
    (st_q == ST_EVAL) ##1 emit_q;
  endsequence
  bus_answer_a: assert property (req && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not after one wait cycle");
  level_follow_a: assert property (level_mode |=> tstate_q == $past(level_now))
    else $error("level trigger not following source");
  demod_thresh_a: assert property (ctrl_q.src_demod && level_mode &&
    ($signed(demod_in) >= $signed(thr_q)) |=> tstate_q)
    else $error("demod at threshold did not read one");
  wave_hold_a: assert property ((st_q == ST_WEND) && wave_busy_in |=> st_q == ST_WEND)
    else $error("left wave wait during playback");
  phase_start_a: assert property ((st_q == ST_WPH) && osc_phase_in[osc_sel_out]
    |=> eval_then_emit)
    else $error("phase hit did not start playback in two cycles");
  phase_hold_a: assert property ((st_q == ST_WPH) && !osc_phase_in[osc_sel_out]
    |=> (st_q == ST_WPH) && !emit_q)
    else $error("emitted before reference phase");
  branch_pick_a: assert property ((st_q == ST_EVAL) && (cmd_q.op == OP_LEVEL)
    |=> emit_q && idx_q == ($past(tstate_q) ? cmd_q.idx_hi : cmd_q.idx_lo))
    else $error("wrong branch taken");
  par_pick_a: assert property ((st_q == ST_EVAL) && (cmd_q.op == OP_PAR)
    |=> idx_q == $past(par_s2_q[IDX_W-1:0]))
    else $error("parallel value not used as index");
  gate_count_a: assert property ((ctrl_q.cnt_mode == CNT_GATED_FREE) && !gate
    |=> cnt_q == $past(cnt_q) || cnt_q == '0)
    else $error("counted outside gate");
  gate_reset_a: assert property ((ctrl_q.cnt_mode == CNT_GATED) && gate && !gate_prev_q
    |=> tmr_q == '0 && cnt_q == '0)
    else $error("gate rise did not reset timer");
endmodule

// File: verilog/sbg_pkg.sv
// shared constants and types for the sequencer branch and gating block
package sbg_pkg;
  // bus and field widths
  localparam int DW = 32;
  localparam int AW = 6;
  localparam int THR_W = 16;
  localparam int IDX_W = 8;
  localparam int TRIG_N = 4;
  localparam int OSC_N = 8;

  // register byte offsets
  localparam logic [AW-1:0] OFF_CTRL = 6'h00;
  localparam logic [AW-1:0] OFF_THRESH = 6'h04;
  localparam logic [AW-1:0] OFF_TIMER = 6'h08;
  localparam logic [AW-1:0] OFF_CMD = 6'h0c;
  localparam logic [AW-1:0] OFF_PARIN = 6'h10;
  localparam logic [AW-1:0] OFF_COUNT = 6'h14;
  localparam logic [AW-1:0] OFF_TRIG = 6'h18;

  // counter run modes
  localparam logic [1:0] CNT_FREE = 2'h0;
  localparam logic [1:0] CNT_GATED_FREE = 2'h1;
  localparam logic [1:0] CNT_GATED = 2'h2;

  // sequencer opcodes
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_LEVEL = 3'h1;
  localparam logic [2:0] OP_PAR = 3'h2;
  localparam logic [2:0] OP_EMIT = 3'h3;

  // reset values
  localparam logic [THR_W-1:0] THRESH_RST = 16'h0000;
  localparam logic [DW-1:0] TIMER_RST = 32'h0000_1000;
  localparam logic [TRIG_N-1:0] TRIG_RST = 4'h0;

  // control word, bits [9:0] of the control register
  typedef struct packed {
    logic [2:0] osc_sel;
    logic [1:0] gate_sel;
    logic [1:0] cnt_mode;
    logic fall_en;
    logic rise_en;
    logic src_demod;
  } sbg_ctrl_type;

  // command word, bits [20:0] of the command register
  typedef struct packed {
    logic [IDX_W-1:0] idx_hi;
    logic [IDX_W-1:0] idx_lo;
    logic wait_phase;
    logic wait_end;
    logic [2:0] op;
  } sbg_cmd_type;

  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WEND = 4'h2,
    ST_WPH = 4'h4,
    ST_EVAL = 4'h8
  } sbg_state_type;
endpackage

// File: sim/sbg_far_model.sv
// far side model: playback engine and oscillator phase source
`timescale 1ns/1ps
module sbg_far_model #(
  parameter int PLAY = 20,
  parameter int PER = 37
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // from the sequencer
  input wire logic emit_req_in,
  // to the sequencer
  output logic wave_busy_out,
  output logic [sbg_pkg::OSC_N-1:0] osc_phase_out
);
  import sbg_pkg::*;
  int play_q;
  int ph_q;
  // one phase source
  // each oscillator hits its reference at its own offset, so a wrong select shows
  always_comb begin
    for (int k = 0; k < OSC_N; k++) begin
      osc_phase_out[k] = (ph_q == 4 * k);
    end
  end
  assign wave_busy_out = (play_q != 0);
  // pattern under period
  // playback length kept below the phase period
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      play_q <= 0;
      ph_q <= 1;
    end else begin
      play_q <= emit_req_in ? PLAY : (play_q != 0 ? play_q - 1 : 0);
      ph_q <= (ph_q == PER - 1) ? 0 : ph_q + 1;
    end
  end
endmodule

// File: sim/sbg_branch_gate_tb_top.sv
// self-checking bench for the sequencer branch and gating block
`timescale 1ns/1ps
module sbg_branch_gate_tb_top;
  import sbg_pkg::*;
  logic clk, reset_in, rd, wr, ext, pulse, busy, emit, tst, sbusy;
  logic [5:0] adr;
  logic [31:0] wd, rdata, par, q;
  logic wreq;
  logic [15:0] demod;
  logic [7:0] phase, idx;
  logic [3:0] trig;
  logic [2:0] osel;
  int fails = 0;
  int samples_checked = 0;
  int since = 0;
  int i;
  logic [15:0] dv [5] = '{16'h0000, 16'h0000, 16'h0100, 16'h00ff, 16'hff00};
  logic [4:0] src = 5'b11100;
  logic [4:0] exv = 5'b00001;
  logic [4:0] hi = 5'b00101;

  sbg_branch_gate dut_u (.clk_in(clk), .reset_in(reset_in), .ce_in(1'b1), .avs_address_in(adr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .ext_trig_in(ext), .par_in(par), .cnt_pulse_in(pulse),
    .demod_in(demod), .osc_phase_in(phase), .wave_busy_in(busy), .emit_req_out(emit),
    .emit_index_out(idx), .seq_trig_out(trig), .osc_sel_out(osel), .trig_state_out(tst),
    .seq_busy_out(sbusy));
  sbg_far_model far_u (.clk_in(clk), .reset_in(reset_in), .emit_req_in(emit), .wave_busy_out(busy),
    .osc_phase_out(phase));

  // cycles since oscillator 5 last hit its reference
  always @(posedge clk) since <= phase[5] ? 0 : since + 1;

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // hold the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    for (n = 0; n < 50 && wreq !== 1'b0; n++) @(posedge clk);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n == 50) begin
      fails++;
      give_verdict();
    end
  endtask

  task automatic rreg(input string nm, input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, e, q);
  endtask

  task automatic wait_emit(input string nm, input logic [7:0] e);
    int n;
    for (n = 0; n < 200 && emit !== 1'b1; n++) @(posedge clk);
    if (n == 200) begin
      fails++;
      give_verdict();
    end
    check(nm, {24'h0, e}, {24'h0, idx});
  endtask

  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      pulse <= 1'b1;
      repeat (2) @(posedge clk);
      pulse <= 1'b0;
      @(posedge clk);
    end
  endtask

  initial begin
    reset_in = 1'b1;
    {rd, wr, ext, pulse} = 4'h0;
    adr = 6'h00;
    wd = 32'h0;
    par = 32'h0;
    demod = 16'h0;
    repeat (2) @(posedge clk);
    reset_in <= 1'b0;
    rreg("timer", OFF_TIMER, TIMER_RST);
    rreg("thresh", OFF_THRESH, 32'h0);
    rreg("trig", OFF_TRIG, 32'h0);
    rreg("unmapped", 6'h1c, 32'h0);
    $display("test reset values done");
    bus(1'b1, OFF_THRESH, 32'h0000_0100);
    for (i = 0; i < 5; i++) begin
      ext <= exv[i];
      demod <= dv[i];
      bus(1'b1, OFF_CTRL, {31'h0, src[i]});
      repeat (5) @(posedge clk);
      check("trig_state", {31'h0, hi[i]}, {31'h0, tst});
      bus(1'b1, OFF_CMD, {11'h0, 8'h22, 8'h11, 2'h0, OP_LEVEL});
      wait_emit("level_index", hi[i] ? 8'h22 : 8'h11);
    end
    $display("test level branch done");
    // rise-only edge mode: a pulse on the pin must stick until a level read consumes it
    bus(1'b1, OFF_CTRL, 32'h0000_0002);
    ext <= 1'b1;
    repeat (5) @(posedge clk);
    ext <= 1'b0;
    repeat (5) @(posedge clk);
    check("edge_sticky", 32'h1, {31'h0, tst});
    bus(1'b1, OFF_CMD, {11'h0, 8'h33, 8'h11, 2'h0, OP_LEVEL});
    wait_emit("edge_index", 8'h33);
    check("edge_cleared", 32'h0, {31'h0, tst});
    rreg("cmd_status", OFF_CMD, 32'h4);
    $display("test edge trigger done");
    par <= 32'ha5c3_965a;
    repeat (4) @(posedge clk);
    bus(1'b1, OFF_CMD, {11'h0, 16'h0, 2'h0, OP_PAR});
    wait_emit("par_index", 8'h5a);
    rreg("parin", OFF_PARIN, 32'ha5c3_965a);
    $display("test parallel branch done");
    bus(1'b1, OFF_CMD, {11'h0, 8'h00, 8'h01, 2'h0, OP_EMIT});
    wait_emit("emit_lo", 8'h01);
    bus(1'b1, OFF_CMD, {11'h0, 8'h00, 8'h02, 2'h1, OP_EMIT});
    bus(1'b1, OFF_CMD, {11'h0, 8'h00, 8'h07, 2'h0, OP_EMIT});
    check("seq_busy", 32'h1, {31'h0, sbusy});
    wait_emit("refused_cmd", 8'h02);
    check("seq_idle", 32'h0, {31'h0, sbusy});
    check("busy_at_emit", 32'h0, {31'h0, busy});
    $display("test wait end done");
    bus(1'b1, OFF_CTRL, 32'h0000_0280);
    // the write lands on the answer edge, so the select shows one edge later
    @(posedge clk);
    check("osc_sel", 32'h5, {29'h0, osel});
    bus(1'b1, OFF_CMD, {11'h0, 8'h00, 8'h44, 2'h2, OP_EMIT});
    wait_emit("phase_index", 8'h44);
    check("phase_delay", 32'h1, since);
    $display("test phase wait done");
    bus(1'b1, OFF_CTRL, 32'h0000_0048);
    bus(1'b1, OFF_TRIG, 32'h1);
    pulses(3);
    bus(1'b1, OFF_TRIG, 32'h4);
    @(posedge clk);
    check("seq_trig", 32'h4, {28'h0, trig});
    pulses(5);
    repeat (4) @(posedge clk);
    bus(1'b1, OFF_TRIG, 32'h0);
    repeat (6) @(posedge clk);
    rreg("count", OFF_COUNT, 32'h5);
    $display("test gated count done");
    // gated mode, 48-cycle period; gate rise placed so an unreset timer would wrap mid-train
    bus(1'b1, OFF_CTRL, 32'h0000_0050);
    bus(1'b1, OFF_TIMER, 32'h0000_0030);
    repeat (30) @(posedge clk);
    bus(1'b1, OFF_TRIG, 32'h4);
    pulses(5);
    repeat (35) @(posedge clk);
    rreg("gated_count", OFF_COUNT, 32'h5);
    $display("test gated reset done");
    give_verdict();
  end
endmodule
